// ---- design/tic_top.sv ----
`timescale 1ns/1ps
`include "tic_regs.svh"

// Summary of operation
// R01: Nesting-off bit 15 of control one blocks nesting; resets to zero.
// R02: Overflow of accumulator A sets bit 14, of B sets bit 13.
// R03: Severe overflow of A sets bit 12, of B sets bit 11.
// R04: Overflow trap per accumulator only while its enable, bit 10 or 9, is set.
// R05: Bit 8 enables severe overflow traps for both accumulators.
// R06: Invalid accumulator shift math trap sets bit 7.
// R07: Divide by zero math trap sets bit 6.
// R08: DMA controller trap sets bit 5; any math trap sets bit 4.
// R09: Address, stack, oscillator traps set bits 3, 2, 1; bit 0 unused.
// R10: Global enable resets to one; when zero blocks interrupts, not traps.
// R11: Bit 14 of control two shows the timed interrupt block status.
// R12: Writing one to bit 13 of control two raises the software trap.
// R13: Bits 2..0 choose falling (1) or rising (0) edge per external input.
// R14: DMA address soft trap sets bit 5 of control three.
// R15: Loop stack overflow soft trap sets bit 4 of control three.
// R16: Software hard trap sets bit 0 of control four; other bits read zero.
// R17: Status bits 11..8 give the new priority level of the pending interrupt.
// R18: Status bits 7..0 give the pending vector; 255 is never produced.
// R19: Trap vectors 0..6 in fixed order, 7 reserved.
// R20: User vectors start at 8 with external zero, then capture unit one.
// R21: Unimplemented bits read zero and ignore writes.
// R22: Request flags set by their source, cleared only by software.
// R23: With nesting off the low three priority bits are not software writable.
// R24: Top priority bit is never software writable.
// R25: Software clears a trap flag by writing zero; a new trap sets it again.
module tic_top
   import tic_pkg::*;
#(
   parameter int NPER = 8
)
(
   input  wire logic                  sys_clk,
   input  wire logic                  reset,
   input  wire logic [7:0]            avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [3:0]            avs_byteenable,
   input  wire logic [31:0]           avs_writedata,
   output logic      [31:0]           avs_readdata,
   output logic                       avs_waitrequest,
   input  wire tic_trap_ev_t          trap_event,
   input  wire logic                  sw_hard_trap_event,
   input  wire logic                  timed_irq_block_active,
   input  wire logic [2:0]            ext_irq_pin,
   input  wire logic [NPER-1:0]       periph_irq,
   input  wire logic [NPER+2:0][2:0]  src_level,
   input  wire logic                  irq_ack,
   input  wire logic                  core_level_we,
   input  wire logic [3:0]            core_level_value,
   output logic                       irq_pending,
   output logic      [3:0]            new_priority_level,
   output logic      [7:0]            pending_vector_number,
   output logic      [3:0]            cpu_priority_level,
   output logic                       nesting_off
);

   localparam int NSRC = NPER + 3;

   tic_bus_state_t    bus_state_reg;
   tic_bus_state_t    bus_state_next;
   logic [31:0]       rdata_reg;
   logic [31:0]       rdata_next;
   logic              wait_reg;
   logic              wait_next;
   logic [15:0]       ctl1_reg;
   logic [15:0]       ctl1_next;
   logic [15:0]       ctl2_reg;
   logic [15:0]       ctl2_next;
   logic [15:0]       ctl3_reg;
   logic [15:0]       ctl3_next;
   logic [15:0]       ctl4_reg;
   logic [15:0]       ctl4_next;
   logic [NSRC-1:0]   req_reg;
   logic [NSRC-1:0]   req_next;
   logic [3:0]        lvl_reg;
   logic [3:0]        lvl_next;
   tic_pend_t         pend_reg;
   tic_pend_t         pend_next;
   logic [15:0]       set1;
   logic [15:0]       set3;
   logic [15:0]       set4;
   logic [15:0]       wval;
   logic [15:0]       ctl2_rd;
   logic [15:0]       pend_rd;
   logic [2:0]        ext_edge;
   logic [NSRC-1:0]   src_evt;
   logic              bus_req;
   logic              do_write;
   logic              soft_trap_request_wr;
   logic              acc_a_trap;
   logic              acc_b_trap;
   logic              sev_a_trap;
   logic              sev_b_trap;
   logic              math_trap;
   logic              user_ok;

   tic_edge_detect
   #(
      .N (3)
   )
   u_edge
   (
      .sys_clk     (sys_clk),
      .reset       (reset),
      .pin_in      (ext_irq_pin),
      .falling_sel (ctl2_reg[`TIC_B_EP_LSB+2:`TIC_B_EP_LSB]), // R13
      .edge_pulse  (ext_edge)
   );

   // Source order fixes the vector: ext0, peripherals, ext1, ext2
   assign src_evt = {ext_edge[2:1], periph_irq, ext_edge[0]}; // R20

   // ---------------- Bus handshake ----------------
   // One wait cycle: request seen, answer on the following cycle
   assign bus_req  = avs_read | avs_write;
   assign do_write = avs_write & (bus_state_reg == TIC_BUS_ACK);

   always_comb
   begin
      wval = {(avs_byteenable[1] ? avs_writedata[15:8] : 8'h00),
              (avs_byteenable[0] ? avs_writedata[7:0] : 8'h00)};
      ctl2_rd = ctl2_reg;
      ctl2_rd[`TIC_B_TIMED_IRQ_BLOCK_ACTIVE] = timed_irq_block_active; // R11
      pend_rd = {4'h0, pend_reg.level, pend_reg.vector}; // R17 R18
      bus_state_next = bus_state_reg;
      wait_next = 1'b1;
      rdata_next = rdata_reg;
      case (bus_state_reg)
         TIC_BUS_IDLE:
         begin
            if (bus_req)
            begin
               bus_state_next = TIC_BUS_ACK;
               wait_next = 1'b0;
               rdata_next = 32'h0000_0000;
               if (avs_read)
               begin
                  case (avs_address)
                     `TIC_OFS_CTL1: rdata_next[15:0] = ctl1_reg;
                     `TIC_OFS_CTL2: rdata_next[15:0] = ctl2_rd;
                     `TIC_OFS_CTL3: rdata_next[15:0] = ctl3_reg;
                     `TIC_OFS_CTL4: rdata_next[15:0] = ctl4_reg; // R16
                     `TIC_OFS_PEND: rdata_next[15:0] = pend_rd;
                     `TIC_OFS_REQ:  rdata_next[NSRC-1:0] = req_reg;
                     `TIC_OFS_LVL:  rdata_next[3:0] = lvl_reg;
                     default:       rdata_next = 32'h0000_0000;
                  endcase
               end
            end
         end
         TIC_BUS_ACK:
         begin
            bus_state_next = TIC_BUS_IDLE;
         end
         default:
         begin
            bus_state_next = TIC_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         bus_state_reg <= TIC_BUS_IDLE;
         wait_reg      <= 1'b1;
         rdata_reg     <= 32'h0000_0000;
      end
      else
      begin
         bus_state_reg <= bus_state_next;
         wait_reg      <= wait_next;
         rdata_reg     <= rdata_next;
      end
   end

   // ---------------- Trap flags ----------------
   always_comb
   begin
      acc_a_trap = trap_event.acc_a_ovf & ctl1_reg[`TIC_B_OVA_EN]; // R04
      acc_b_trap = trap_event.acc_b_ovf & ctl1_reg[`TIC_B_OVB_EN]; // R04
      sev_a_trap = trap_event.acc_a_severe & ctl1_reg[`TIC_B_SEV_EN]; // R05
      sev_b_trap = trap_event.acc_b_severe & ctl1_reg[`TIC_B_SEV_EN]; // R05
      math_trap = acc_a_trap | acc_b_trap | sev_a_trap | sev_b_trap
                | trap_event.bad_shift | trap_event.zero_divide;
      soft_trap_request_wr = do_write & (avs_address == `TIC_OFS_CTL2)
                & wval[`TIC_B_SOFT_TRAP_REQUEST];
      set1 = 16'h0000;
      set1[`TIC_B_OVA_FLAG]  = acc_a_trap; // R02
      set1[`TIC_B_OVB_FLAG]  = acc_b_trap; // R02
      set1[`TIC_B_SEVA_FLAG] = sev_a_trap; // R03
      set1[`TIC_B_SEVB_FLAG] = sev_b_trap; // R03
      set1[`TIC_B_SHIFT]     = trap_event.bad_shift; // R06
      set1[`TIC_B_DIV0]      = trap_event.zero_divide; // R07
      set1[`TIC_B_DMA]       = trap_event.dma_ctrl; // R08
      set1[`TIC_B_MATH]      = math_trap; // R08
      set1[`TIC_B_ADDR]      = trap_event.address; // R09
      set1[`TIC_B_STACK]     = trap_event.stack; // R09
      set1[`TIC_B_OSC]       = trap_event.osc_fail; // R09
      set3 = 16'h0000;
      set3[`TIC_B_DMA_ADDR]  = trap_event.dma_address; // R14
      set3[`TIC_B_LOOP_OVF]  = trap_event.loop_stack_ovf; // R15
      set4 = 16'h0000;
      set4[`TIC_B_SW_HARD]   = sw_hard_trap_event | soft_trap_request_wr; // R12 R16
      ctl1_next = ctl1_reg;
      ctl2_next = ctl2_reg;
      ctl3_next = ctl3_reg;
      ctl4_next = ctl4_reg;
      if (do_write)
      begin
         case (avs_address)
            `TIC_OFS_CTL1: ctl1_next = wval;
            `TIC_OFS_CTL2: ctl2_next = wval;
            `TIC_OFS_CTL3: ctl3_next = wval;
            `TIC_OFS_CTL4: ctl4_next = wval;
            default:       ctl1_next = ctl1_reg;
         endcase
      end
      // New event beats a software clear in the same cycle
      ctl1_next = (ctl1_next | set1) & `TIC_CTL1_MASK; // R21 R25
      ctl2_next = ctl2_next & `TIC_CTL2_MASK; // R21
      ctl3_next = (ctl3_next | set3) & `TIC_CTL3_MASK; // R21 R25
      ctl4_next = (ctl4_next | set4) & `TIC_CTL4_MASK; // R21 R25
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         ctl1_reg <= `TIC_CTL1_RST; // R01
         ctl2_reg <= `TIC_CTL2_RST; // R10
         ctl3_reg <= `TIC_CTL3_RST;
         ctl4_reg <= `TIC_CTL4_RST;
      end
      else
      begin
         ctl1_reg <= ctl1_next;
         ctl2_reg <= ctl2_next;
         ctl3_reg <= ctl3_next;
         ctl4_reg <= ctl4_next;
      end
   end

   // ---------------- Request flags ----------------
   genvar s;
   generate
      for (s = 0; s < NSRC; s++)
      begin : g_req
         always_comb
         begin
            req_next[s] = req_reg[s];
            if (do_write && (avs_address == `TIC_OFS_REQ) && !avs_writedata[s])
               req_next[s] = 1'b0;
            if (src_evt[s])
               req_next[s] = 1'b1; // R22
         end
      end
   endgenerate

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         req_reg <= '0;
      else
         req_reg <= req_next;
   end

   // ---------------- CPU priority level ----------------
   always_comb
   begin
      lvl_next = lvl_reg;
      if (do_write && (avs_address == `TIC_OFS_LVL) && avs_byteenable[0]
          && !ctl1_reg[`TIC_B_NEST]) // R23
         lvl_next[2:0] = avs_writedata[2:0]; // R24
      if (core_level_we)
         lvl_next = core_level_value;
      if (irq_ack && pend_reg.valid)
      begin
         // Nesting off: a taken user interrupt lifts the CPU to the user maximum
         if (ctl1_reg[`TIC_B_NEST] && (pend_reg.level <= `TIC_LVL_USER_MAX))
            lvl_next = `TIC_LVL_USER_MAX; // R01
         else
            lvl_next = pend_reg.level;
      end
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         lvl_reg <= 4'h0;
      else
         lvl_reg <= lvl_next;
   end

   // ---------------- Pending vector and level ----------------
   // Traps first in fixed order; users by level, lowest vector on a tie
   always_comb
   begin
      // Rebuilt each cycle: a held trap vector would never let go
      pend_next = '{valid: 1'b0, level: 4'h0, vector: `TIC_VEC_USER};
      user_ok = ctl2_reg[`TIC_B_GIE] & ~timed_irq_block_active; // R10
      for (int k = NSRC - 1; k >= 0; k--)
      begin
         if (user_ok && req_reg[k] && ({1'b0, src_level[k]} > lvl_reg)
             && (!pend_next.valid || ({1'b0, src_level[k]} >= pend_next.level)))
         begin
            pend_next.valid  = 1'b1;
            pend_next.level  = {1'b0, src_level[k]}; // R17
            pend_next.vector = `TIC_VEC_USER + 8'(k); // R18 R20
         end
      end
      if (ctl3_reg[`TIC_B_DMA_ADDR] || ctl3_reg[`TIC_B_LOOP_OVF])
         pend_next.vector = `TIC_VEC_SOFT; // R19
      if (ctl1_reg[`TIC_B_DMA])
         pend_next.vector = `TIC_VEC_DMA; // R19
      if (ctl1_reg[`TIC_B_MATH])
         pend_next.vector = `TIC_VEC_MATH; // R19
      if (ctl1_reg[`TIC_B_STACK])
         pend_next.vector = `TIC_VEC_STACK; // R19
      if (ctl4_reg[`TIC_B_SW_HARD])
         pend_next.vector = `TIC_VEC_HARD; // R19
      if (ctl1_reg[`TIC_B_ADDR])
         pend_next.vector = `TIC_VEC_ADDR; // R19
      if (ctl1_reg[`TIC_B_OSC])
         pend_next.vector = `TIC_VEC_OSC; // R19
      if (pend_next.vector < `TIC_VEC_USER)
      begin
         pend_next.valid = 1'b1;
         pend_next.level = `TIC_LVL_TOP - pend_next.vector[3:0]; // R17
      end
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         pend_reg <= '{valid: 1'b0, level: 4'h0, vector: `TIC_VEC_USER};
      else
         pend_reg <= pend_next;
   end

   assign avs_readdata          = rdata_reg;
   assign avs_waitrequest       = wait_reg;
   assign irq_pending           = pend_reg.valid;
   assign new_priority_level    = pend_reg.level;
   assign pending_vector_number = pend_reg.vector;
   assign cpu_priority_level    = lvl_reg;
   assign nesting_off           = ctl1_reg[`TIC_B_NEST];

endmodule

// ---- pkg/tic_regs.svh ----
`ifndef TIC_REGS_SVH
`define TIC_REGS_SVH

// Byte offsets on the register bus
`define TIC_OFS_CTL1      8'h00
`define TIC_OFS_CTL2      8'h04
`define TIC_OFS_CTL3      8'h08
`define TIC_OFS_CTL4      8'h0C
`define TIC_OFS_PEND      8'h10
`define TIC_OFS_REQ       8'h14
`define TIC_OFS_LVL       8'h18

// trap_and_nesting_control fields
`define TIC_B_NEST        15
`define TIC_B_OVA_FLAG    14
`define TIC_B_OVB_FLAG    13
`define TIC_B_SEVA_FLAG   12
`define TIC_B_SEVB_FLAG   11
`define TIC_B_OVA_EN      10
`define TIC_B_OVB_EN      9
`define TIC_B_SEV_EN      8
`define TIC_B_SHIFT       7
`define TIC_B_DIV0        6
`define TIC_B_DMA         5
`define TIC_B_MATH        4
`define TIC_B_ADDR        3
`define TIC_B_STACK       2
`define TIC_B_OSC         1

// global_enable_and_edge_select fields
`define TIC_B_GIE         15
`define TIC_B_TIMED_IRQ_BLOCK_ACTIVE        14
`define TIC_B_SOFT_TRAP_REQUEST      13
`define TIC_B_EP_LSB      0

// soft_trap_status and software_hard_trap_status fields
`define TIC_B_DMA_ADDR    5
`define TIC_B_LOOP_OVF    4
`define TIC_B_SW_HARD     0

// Implemented bit masks and reset values
`define TIC_CTL1_MASK     16'hFFFE
`define TIC_CTL2_MASK     16'hA007
`define TIC_CTL3_MASK     16'h0030
`define TIC_CTL4_MASK     16'h0001
`define TIC_CTL1_RST      16'h0000
`define TIC_CTL2_RST      16'h8000
`define TIC_CTL3_RST      16'h0000
`define TIC_CTL4_RST      16'h0000

// Vector numbers and levels
`define TIC_VEC_OSC       8'h00
`define TIC_VEC_ADDR      8'h01
`define TIC_VEC_HARD      8'h02
`define TIC_VEC_STACK     8'h03
`define TIC_VEC_MATH      8'h04
`define TIC_VEC_DMA       8'h05
`define TIC_VEC_SOFT      8'h06
`define TIC_VEC_USER      8'h08
`define TIC_LVL_TOP       4'hF
`define TIC_LVL_USER_MAX  4'h7

`endif

// ---- pkg/tic_pkg.sv ----
package tic_pkg;

   typedef struct packed
   {
      logic acc_a_ovf;
      logic acc_b_ovf;
      logic acc_a_severe;
      logic acc_b_severe;
      logic bad_shift;
      logic zero_divide;
      logic dma_ctrl;
      logic address;
      logic stack;
      logic osc_fail;
      logic dma_address;
      logic loop_stack_ovf;
   } tic_trap_ev_t;

   typedef struct packed
   {
      logic       valid;
      logic [3:0] level;
      logic [7:0] vector;
   } tic_pend_t;

   typedef enum logic [0:0] {TIC_BUS_IDLE, TIC_BUS_ACK} tic_bus_state_t;

endpackage

// ---- design/tic_edge_detect.sv ----
`timescale 1ns/1ps

module tic_edge_detect
#(
   parameter int N = 3
)
(
   input  wire logic         sys_clk,
   input  wire logic         reset,
   input  wire logic [N-1:0] pin_in,
   input  wire logic [N-1:0] falling_sel,
   output logic      [N-1:0] edge_pulse
);

   logic [N-1:0] meta_reg;
   logic [N-1:0] sync_reg;
   logic [N-1:0] prev_reg;
   logic [N-1:0] pulse_reg;
   logic [N-1:0] pulse_next;

   genvar i;
   generate
      for (i = 0; i < N; i++)
      begin : g_pin
         // Polarity chosen per pin; only the settled copy is compared
         always_comb
         begin
            if (falling_sel[i])
               pulse_next[i] = prev_reg[i] & ~sync_reg[i]; // R13
            else
               pulse_next[i] = ~prev_reg[i] & sync_reg[i]; // R13
         end
      end
   endgenerate

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         meta_reg  <= '0;
         sync_reg  <= '0;
         prev_reg  <= '0;
         pulse_reg <= '0;
      end
      else
      begin
         meta_reg  <= pin_in;
         sync_reg  <= meta_reg;
         prev_reg  <= sync_reg;
         pulse_reg <= pulse_next;
      end
   end

   assign edge_pulse = pulse_reg;

endmodule

// ---- verif/tic_top_properties.sv ----
`timescale 1ns/1ps
module tic_checker
   import tic_pkg::*;
#(
   parameter int NPER = 8
)
(
   input wire logic         sys_clk,
   input wire logic         reset,
   input wire logic [7:0]   avs_address,
   input wire logic         avs_read,
   input wire logic         avs_write,
   input wire logic [3:0]   avs_byteenable,
   input wire logic [31:0]  avs_writedata,
   input wire logic [31:0]  avs_readdata,
   input wire logic         avs_waitrequest,
   input wire tic_trap_ev_t trap_event,
   input wire logic         sw_hard_trap_event,
   input wire logic         irq_ack,
   input wire logic         core_level_we,
   input wire logic         irq_pending,
   input wire logic [3:0]   new_priority_level,
   input wire logic [7:0]   pending_vector_number,
   input wire logic [3:0]   cpu_priority_level,
   input wire logic         nesting_off
);
   logic wr_ok;
   logic rd_ok;
   logic lvl_wr;
   assign wr_ok = avs_write && !avs_waitrequest;
   assign rd_ok = avs_read && !avs_waitrequest;
   // Core updates excluded: they may legally move the level
   assign lvl_wr = wr_ok && avs_address == 8'h18 && !irq_ack && !core_level_we;

   default clocking dc @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   nest_write_a:
      assert property (wr_ok && avs_address == 8'h00 && avs_byteenable[1]
         |=> nesting_off == $past(avs_writedata[15]))
      else $error("nesting control does not follow the write");
   vec_reserved_a:
      assert property (pending_vector_number != 8'hFF)
      else $error("reserved vector shown");
   trap_level_a:
      assert property (irq_pending && pending_vector_number < 8'h08 |->
         pending_vector_number != 8'h07 &&
         new_priority_level == 4'hF - pending_vector_number[3:0])
      else $error("trap vector and level disagree");
   user_level_a:
      assert property (irq_pending && pending_vector_number >= 8'h08 |->
         new_priority_level inside {[4'h1:4'h7]})
      else $error("user vector with a trap level");
   top_bit_a:
      assert property (lvl_wr |=> cpu_priority_level[3] == $past(cpu_priority_level[3]))
      else $error("software changed the top priority bit");
   low_bits_a:
      assert property (lvl_wr && nesting_off |=> $stable(cpu_priority_level))
      else $error("priority level written while nesting is off");
   osc_first_a:
      assert property (trap_event.osc_fail |-> ##2 irq_pending &&
         pending_vector_number == 8'h00)
      else $error("oscillator trap not pending in time");
   sw_hard_a:
      assert property (sw_hard_trap_event |-> ##2 irq_pending &&
         pending_vector_number <= 8'h02)
      else $error("software hard trap not pending in time");
   upper_zero_a:
      assert property (rd_ok |-> avs_readdata[31:16] == 16'h0000 &&
         (avs_address != 8'h0C || avs_readdata[15:1] == 15'h0000))
      else $error("unimplemented bits read nonzero");
endmodule

bind tic_top tic_checker #(.NPER(NPER)) chk
(
   .sys_clk, .reset, .avs_address, .avs_read, .avs_write, .avs_byteenable,
   .avs_writedata, .avs_readdata, .avs_waitrequest, .trap_event, .sw_hard_trap_event,
   .irq_ack, .core_level_we, .irq_pending, .new_priority_level, .pending_vector_number,
   .cpu_priority_level, .nesting_off
);

// ---- verif/tic_core_model.sv ----
`timescale 1ns/1ps
module tic_core_model
(
   input  wire logic       sys_clk,
   input  wire logic       reset,
   input  wire logic       ack_en,
   input  wire logic [3:0] ack_delay,
   input  wire logic       ret,
   input  wire logic       irq_pending,
   output logic            irq_ack,
   output logic            core_level_we,
   output logic      [3:0] core_level_value
);
   logic [3:0] wait_reg;
   logic       done_reg;
   // One acceptance per enable: pending lags the level by a cycle
   assign core_level_value = 4'h0;
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         wait_reg      <= 4'h0;
         done_reg      <= 1'h0;
         irq_ack       <= 1'h0;
         core_level_we <= 1'h0;
      end
      else
      begin
         irq_ack       <= 1'h0;
         core_level_we <= ret;
         if (!ack_en)
            done_reg <= 1'h0;
         if (!ack_en || !irq_pending || done_reg)
            wait_reg <= 4'h0;
         else if (wait_reg == ack_delay)
         begin
            irq_ack  <= 1'h1;
            done_reg <= 1'h1;
         end
         else
            wait_reg <= wait_reg + 4'h1;
      end
   end
endmodule

// ---- verif/trap_and_interrupt_control_regs_test.sv ----
`timescale 1ns/1ps
module trap_and_interrupt_control_regs_test
   import tic_pkg::*;
;
   typedef struct packed
   {
      logic [7:0]  a;
      logic [15:0] w;
      logic [12:0] ev;
      logic [15:0] e;
      logic [7:0]  v;
   } tic_row_t;
   logic             sys_clk = 1'h0;
   logic             reset = 1'h1;
   logic [7:0]       avs_address = 8'h00;
   logic             avs_read = 1'h0;
   logic             avs_write = 1'h0;
   logic [3:0]       avs_byteenable = 4'hF;
   logic [31:0]      avs_writedata = 32'h0;
   logic [31:0]      avs_readdata;
   logic             avs_waitrequest;
   tic_trap_ev_t     trap_event = '0;
   logic             sw_hard_trap_event = 1'h0;
   logic             timed_irq_block_active = 1'h0;
   logic [2:0]       ext_irq_pin = 3'h0;
   logic [7:0]       periph_irq = 8'h00;
   logic [10:0][2:0] src_level = '0;
   logic             irq_ack, core_level_we, irq_pending, nesting_off;
   logic [3:0]       core_level_value, new_priority_level, cpu_priority_level;
   logic [7:0]       pending_vector_number;
   logic             ack_en = 1'h0;
   logic             ret = 1'h0;
   logic [15:0]      rd;
   int               n_mismatch = 0;
   int               n_checks = 0;
   // Event field order msb..lsb: swHard ovA ovB sevA sevB shift div0 dma addr stk osc dmaA loop
   tic_row_t rows [19] = '{
      '{8'h00, 16'h0700, 13'h0800, 16'h4710, 8'h04},
      '{8'h00, 16'h0700, 13'h0400, 16'h2710, 8'h04},
      '{8'h00, 16'h0100, 13'h0200, 16'h1110, 8'h04},
      '{8'h00, 16'h0100, 13'h0100, 16'h0910, 8'h04},
      '{8'h00, 16'h0600, 13'h0300, 16'h0600, 8'hFF},
      '{8'h00, 16'h0100, 13'h0C00, 16'h0100, 8'hFF},
      '{8'h00, 16'h0000, 13'h0080, 16'h0090, 8'h04},
      '{8'h00, 16'h0000, 13'h0040, 16'h0050, 8'h04},
      '{8'h00, 16'h0000, 13'h0020, 16'h0020, 8'h05},
      '{8'h00, 16'h0000, 13'h0010, 16'h0008, 8'h01},
      '{8'h00, 16'h0000, 13'h0008, 16'h0004, 8'h03},
      '{8'h00, 16'h0000, 13'h0004, 16'h0002, 8'h00},
      '{8'h08, 16'h0000, 13'h0002, 16'h0020, 8'h06},
      '{8'h08, 16'h0000, 13'h0001, 16'h0010, 8'h06},
      '{8'h0C, 16'h0000, 13'h1000, 16'h0001, 8'h02},
      '{8'h00, 16'hFFFF, 13'h0000, 16'hFFFE, 8'h00},
      '{8'h08, 16'hFFFF, 13'h0000, 16'h0030, 8'h06},
      '{8'h20, 16'hFFFF, 13'h0000, 16'h0000, 8'hFF},
      '{8'h04, 16'hFFFF, 13'h0000, 16'hA007, 8'h02}
   };

   always #2.5 sys_clk = ~sys_clk;

   tic_top #(.NPER(8)) uut
   (
      .sys_clk, .reset, .avs_address, .avs_read, .avs_write, .avs_byteenable,
      .avs_writedata, .avs_readdata, .avs_waitrequest, .trap_event, .sw_hard_trap_event,
      .timed_irq_block_active, .ext_irq_pin, .periph_irq, .src_level, .irq_ack,
      .core_level_we, .core_level_value, .irq_pending, .new_priority_level,
      .pending_vector_number, .cpu_priority_level, .nesting_off
   );

   tic_core_model core
   (
      .sys_clk, .reset, .ack_en, .ack_delay(4'h3), .ret, .irq_pending, .irq_ack,
      .core_level_we, .core_level_value
   );

   task automatic finish_test();
      if (n_mismatch == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // Request held until the edge that sees waitrequest low; one idle edge after
   task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] w);
      int k = 0;
      avs_address   <= a;
      avs_writedata <= {16'h0000, w};
      avs_read      <= !wr;
      avs_write     <= wr;
      do
      begin
         @(posedge sys_clk);
         k++;
      end
      while (avs_waitrequest !== 1'h0 && k < 50);
      if (k >= 50)
      begin
         n_mismatch++;
         finish_test();
      end
      rd = avs_readdata[15:0];
      avs_read  <= 1'h0;
      avs_write <= 1'h0;
      @(posedge sys_clk);
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [15:0] e);
      bus(1'h0, a, 16'h0000);
      check(what, rd, e);
   endtask

   task automatic pend_chk(input logic [7:0] v, input logic [3:0] l);
      if (v == 8'hFF)
         check("pending", {15'h0000, irq_pending}, 16'h0000);
      else
         check("vector", {3'h0, irq_pending, new_priority_level, pending_vector_number},
               {4'h1, l, v});
   endtask

   initial
   begin
      tick(3);
      reset <= 1'h0;
      @(posedge sys_clk);
      foreach (rows[i])
      begin
         bus(1'h1, rows[i].a, rows[i].w);
         {sw_hard_trap_event, trap_event} <= rows[i].ev;
         @(posedge sys_clk);
         {sw_hard_trap_event, trap_event} <= 13'h0000;
         tick(3);
         rd_chk("register", rows[i].a, rows[i].e);
         pend_chk(rows[i].v, 4'hF - rows[i].v[3:0]);
         bus(1'h1, rows[i].a, 16'h0000);
      end
      reset <= 1'h1;
      tick(3);
      reset <= 1'h0;
      @(posedge sys_clk);
      rd_chk("ctl1 reset", 8'h00, 16'h0000);
      rd_chk("ctl2 reset", 8'h04, 16'h8000);
      rd_chk("ctl3 reset", 8'h08, 16'h0000);
      rd_chk("ctl4 reset", 8'h0C, 16'h0000);
      src_level[0] <= 3'h3;
      src_level[1] <= 3'h2;
      bus(1'h1, 8'h04, 16'h8001);
      ext_irq_pin[0] <= 1'h1;
      tick(8);
      pend_chk(8'hFF, 4'h0);
      ext_irq_pin[0] <= 1'h0;
      tick(8);
      pend_chk(8'h08, 4'h3);
      bus(1'h1, 8'h14, 16'h0000);
      periph_irq[0] <= 1'h1;
      @(posedge sys_clk);
      periph_irq[0] <= 1'h0;
      tick(3);
      pend_chk(8'h09, 4'h2);
      bus(1'h1, 8'h04, 16'h0000);
      tick(2);
      pend_chk(8'hFF, 4'h0);
      timed_irq_block_active <= 1'h1;
      bus(1'h1, 8'h04, 16'h8000);
      rd_chk("timed block", 8'h04, 16'hC000);
      pend_chk(8'hFF, 4'h0);
      timed_irq_block_active <= 1'h0;
      tick(2);
      pend_chk(8'h09, 4'h2);
      ack_en <= 1'h1;
      tick(8);
      check("cpu level", {12'h000, cpu_priority_level}, 16'h0002);
      pend_chk(8'hFF, 4'h0);
      bus(1'h1, 8'h00, 16'h8000);
      check("nesting", {15'h0000, nesting_off}, 16'h0001);
      bus(1'h1, 8'h18, 16'h0005);
      rd_chk("level locked", 8'h18, 16'h0002);
      bus(1'h1, 8'h00, 16'h0000);
      bus(1'h1, 8'h18, 16'h000F);
      rd_chk("level top", 8'h18, 16'h0007);
      ret <= 1'h1;
      @(posedge sys_clk);
      ret <= 1'h0;
      tick(3);
      pend_chk(8'h09, 4'h2);
      bus(1'h1, 8'h00, 16'h8000);
      ack_en <= 1'h0;
      @(posedge sys_clk);
      ack_en <= 1'h1;
      tick(8);
      check("nested level", {12'h000, cpu_priority_level}, 16'h0007);
      src_level[9] <= 3'h5;
      ext_irq_pin[1] <= 1'h1;
      ret <= 1'h1;
      tick(8);
      pend_chk(8'h11, 4'h5);
      finish_test();
   end
endmodule
